/* common/dsm_regs.svh */
// constants of the pll status and mode-pin block
// assumes a 10 MHz master clock; included by bare name
`ifndef DSM_REGS_SVH
`define DSM_REGS_SVH

`define DSM_CLK_PERIOD_NS 100
`define DSM_RESET_HOLD_NS 3000000
`define DSM_RESET_HOLD_CYC ((`DSM_RESET_HOLD_NS + `DSM_CLK_PERIOD_NS - 1) / `DSM_CLK_PERIOD_NS)

`define DSM_MODE_NORMAL 2'h0
`define DSM_MODE_HOLD 2'h1
`define DSM_MODE_FREE 2'h2
`define DSM_MODE_AUTO 2'h3

`define DSM_OOR_LIMIT0 16'h0004
`define DSM_OOR_LIMIT1 16'h0006
`define DSM_OOR_LIMIT2 16'h0008
`define DSM_OOR_LIMIT3 16'h0008

`define DSM_GATE_LAST 16'h03ff
`define DSM_REF_NOMINAL 16'h0080
`define DSM_JUMP_LIMIT 16'h0002
`define DSM_LOCK_SETTLE 16'h0100
`define DSM_CNT_MAX 16'hffff

`define DSM_REG_CTRL 8'h00
`define DSM_REG_STATUS 8'h04
`define DSM_REG_INT_STAT 8'h08
`define DSM_REG_INT_MASK 8'h0c
`define DSM_REG_DELAY 8'h10

`define DSM_CTRL_REF 1:0
`define DSM_EV_FIELD 4:0
`define DSM_REF_NONE 2'h3

`endif

/* common/dsm_pkg.sv */
// types shared by the pll status and mode-pin block
// no assumptions beyond a single clock domain
package dsm_pkg;

  typedef enum logic [3:0] {
    ST_RST = 4'b0001,
    ST_FREE = 4'b0010,
    ST_NORMAL = 4'b0100,
    ST_HOLD = 4'b1000
  } dsm_state_t;

  typedef struct packed {
    logic hit;
    logic [1:0] app;
    logic [1:0] mode;
    logic [2:0] refs;
  } dsm_pins_t;

  function automatic logic [15:0] dsm_absdiff(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

endpackage

/* common/dsm_tie_if.sv */
// carrier between mode control and the phase error corrector
// one clock domain, driven by the status block
`timescale 1ns/100ps
interface dsm_tie_if;
  logic retEvt;
  logic hitless;
  logic [15:0] phase;
  logic [15:0] delay;
  modport ctl (output retEvt, output hitless, output phase, input delay);
  modport corr (input retEvt, input hitless, input phase, output delay);
endinterface

/* hdl/dsm_ref_monitor.sv */
// frequency and stability monitor for one reference
// expects a reference level already synchronised to clock
`timescale 1ns/100ps
`include "dsm_regs.svh"
module dsm_ref_monitor
  import dsm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // reference and limit
  input wire logic refLevel,
  input wire logic [15:0] oorLimit,
  // result
  output logic fault
);
  logic prev_reg, prev_next, fault_reg, fault_next, jump_reg, jump_next, valid_reg, valid_next;
  logic [15:0] gate_reg, gate_next, edges_reg, edges_next, per_reg, per_next;
  logic [15:0] last_reg, last_next;
  logic edgeSeen, gateEnd, jumpNow, oorNow;

  always_comb begin
    edgeSeen = refLevel & ~prev_reg;
    gateEnd = (gate_reg == `DSM_GATE_LAST);
    jumpNow = edgeSeen & valid_reg &
              (dsm_absdiff(per_reg, last_reg) > `DSM_JUMP_LIMIT);
    oorNow = dsm_absdiff(edges_reg, `DSM_REF_NOMINAL) > oorLimit;
    prev_next = refLevel;
    gate_next = gateEnd ? 16'h0 : gate_reg + 16'h1;
    edges_next = gateEnd ? 16'h0 : edges_reg + {15'h0, edgeSeen};
    per_next = edgeSeen ? 16'h0 : (per_reg == `DSM_CNT_MAX ? per_reg : per_reg + 16'h1);
    last_next = edgeSeen ? per_reg : last_reg;
    valid_next = valid_reg | edgeSeen;
    jump_next = gateEnd ? 1'b0 : (jump_reg | jumpNow);
    // a window result replaces the flag; a jump raises it at once
    fault_next = gateEnd ? (oorNow | jump_reg | jumpNow) : (fault_reg | jumpNow);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      prev_reg <= 1'b0;
      gate_reg <= 16'h0;
      edges_reg <= 16'h0;
      per_reg <= 16'h0;
      last_reg <= 16'h0;
      valid_reg <= 1'b0;
      jump_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      gate_reg <= gate_next;
      edges_reg <= edges_next;
      per_reg <= per_next;
      last_reg <= last_next;
      valid_reg <= valid_next;
      jump_reg <= jump_next;
      fault_reg <= fault_next;
    end
  end

  assign fault = fault_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  jump_fault_a: assert property (jumpNow |=> fault)
    else $error("phase jump did not raise fault");
  window_oor_a: assert property (gateEnd && oorNow |=> fault && gate_reg == 16'h0)
    else $error("out of range window did not raise fault");
endmodule

/* hdl/dsm_phase_corrector.sv */
// phase error corrector: keeps or remeasures the stored delay
// the controller raises retEvt for one cycle on a same-reference return
`timescale 1ns/100ps
module dsm_phase_corrector
  import dsm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // control side
  dsm_tie_if.corr bus
);
  logic [15:0] delay_reg, delay_next;

  always_comb begin
    delay_next = delay_reg;
    if (bus.retEvt && bus.hitless) begin
      delay_next = bus.phase;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      delay_reg <= 16'h0;
    end else begin
      delay_reg <= delay_next;
    end
  end

  assign bus.delay = delay_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  keep_delay_a: assert property (bus.retEvt && !bus.hitless |=> $stable(delay_reg))
    else $error("delay changed on a non-hitless return");
  fresh_delay_a: assert property (bus.retEvt && bus.hitless |=> delay_reg == $past(bus.phase))
    else $error("delay not remeasured on a hitless return");
endmodule

/* hdl/dsm_status_mode.sv */
// pll status pins, mode-pin decoding, internal reset hold and register port
// pins are asynchronous to clock; register port is on clock
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "dsm_regs.svh"
// Function
// - lock output high only while locked to the selected reference.
// - holdover output high whenever the loop is in holdover.
// - each reference fault flag rises when its frequency leaves the profile limit.
// - a fault flag also rises on abrupt phase or frequency jumps.
// - hitless select low: keep stored corrector delay on same-reference return.
// - hitless select high: measure a fresh corrector delay on that return.
// - the two mode bits decode together as one field selecting the mode.
// - the two profile bits decode together and choose the out-of-range limit.
// - after reset release, stay in internal reset 3 ms with clock outputs released.
module dsm_status_mode
  import dsm_pkg::*;
#(
  parameter int RESET_HOLD_CYC = `DSM_RESET_HOLD_CYC,
  parameter logic [1:0] MODE_NORMAL = `DSM_MODE_NORMAL,
  parameter logic [1:0] MODE_HOLD = `DSM_MODE_HOLD,
  parameter logic [1:0] MODE_FREE = `DSM_MODE_FREE,
  parameter logic [1:0] MODE_AUTO = `DSM_MODE_AUTO,
  parameter logic [15:0] OOR_LIMIT0 = `DSM_OOR_LIMIT0,
  parameter logic [15:0] OOR_LIMIT1 = `DSM_OOR_LIMIT1,
  parameter logic [15:0] OOR_LIMIT2 = `DSM_OOR_LIMIT2,
  parameter logic [15:0] OOR_LIMIT3 = `DSM_OOR_LIMIT3
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // board pins
  input wire logic [2:0] refClkPin,
  input wire logic op_mode_bit0,
  input wire logic op_mode_bit1,
  input wire logic [1:0] application_profile,
  input wire logic hitless_return_select,
  // status pins
  output logic lockIndicator,
  output logic holdoverIndicator,
  output logic ref_a_fault_flag,
  output logic ref_b_fault_flag,
  output logic ref_c_fault_flag,
  output logic clkOutEn_n,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdData,
  output logic irq,
  // corrector delay
  output logic [15:0] corrDelay
);
  localparam int NPIN = $bits(dsm_pins_t);
  localparam logic [15:0] RST_LAST = 16'(RESET_HOLD_CYC - 1);

  dsm_pins_t pinRaw, meta_reg, sync_reg;
  logic [2:0] refFault, refPrev_reg, refPrev_next;
  logic [15:0] oorLimit;
  dsm_state_t st_reg, st_next;
  logic [15:0] rstCnt_reg, rstCnt_next, settle_reg, settle_next, phase_reg, phase_next;
  logic [1:0] curRef_reg, curRef_next, wantRef;
  logic history_reg, history_next, lock_reg, lock_next, hold_reg, hold_next;
  logic oen_reg, oen_next, inReset, monRst, retEvt, selEdge;
  logic [1:0] ctrlRef_reg, ctrlRef_next;
  logic [4:0] intStat_reg, intStat_next, mask_reg, mask_next, events;
  logic [2:0] faultPrev_reg, faultPrev_next;
  logic [31:0] rd_reg, rd_next;
  logic irq_reg, irq_next;
  dsm_tie_if tieBus();

  function automatic logic refOk(input logic [2:0] f, input logic [1:0] idx);
    return (idx != `DSM_REF_NONE) && !f[idx];
  endfunction

  // every pin passes two flops before any logic sees it
  assign pinRaw = '{hit: hitless_return_select, app: application_profile,
                    mode: {op_mode_bit1, op_mode_bit0}, refs: refClkPin};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clock) begin
        if (srst) begin
          meta_reg[gi] <= 1'b0;
          sync_reg[gi] <= 1'b0;
        end else begin
          meta_reg[gi] <= pinRaw[gi];
          sync_reg[gi] <= meta_reg[gi];
        end
      end
    end
    for (gi = 0; gi < 3; gi++) begin : g_mon
      dsm_ref_monitor u_mon (
        .clock(clock),
        .srst(monRst),
        .refLevel(sync_reg.refs[gi]),
        .oorLimit(oorLimit),
        .fault(refFault[gi])
      );
    end
  endgenerate

  always_comb begin
    oorLimit = OOR_LIMIT3;
    if (sync_reg.app == 2'h0) begin
      oorLimit = OOR_LIMIT0;
    end else if (sync_reg.app == 2'h1) begin
      oorLimit = OOR_LIMIT1;
    end else if (sync_reg.app == 2'h2) begin
      oorLimit = OOR_LIMIT2;
    end
  end

  assign inReset = (st_reg == ST_RST);
  // monitors restart with the device so no stale fault leaks out of reset
  assign monRst = srst | inReset;

  always_comb begin
    wantRef = (ctrlRef_reg == `DSM_REF_NONE) ? 2'h0 : ctrlRef_reg;
    if (sync_reg.mode == MODE_AUTO) begin
      if (refOk(refFault, 2'h0)) wantRef = 2'h0;
      else if (refOk(refFault, 2'h1)) wantRef = 2'h1;
      else if (refOk(refFault, 2'h2)) wantRef = 2'h2;
      else wantRef = curRef_reg;
    end
    st_next = st_reg;
    rstCnt_next = rstCnt_reg;
    case (st_reg)
      ST_RST: begin
        rstCnt_next = rstCnt_reg + 16'h1;
        if (rstCnt_reg == RST_LAST) st_next = ST_FREE;
      end
      default: begin
        if (sync_reg.mode == MODE_FREE) st_next = ST_FREE;
        else if (sync_reg.mode == MODE_HOLD) st_next = history_reg ? ST_HOLD : ST_FREE;
        else if (refOk(refFault, wantRef)) st_next = ST_NORMAL;
        else st_next = history_reg ? ST_HOLD : ST_FREE;
      end
    endcase
    curRef_next = (st_next == ST_NORMAL) ? wantRef : curRef_reg;
    // only a return to the reference already used counts for the corrector
    retEvt = (st_reg == ST_HOLD || st_reg == ST_FREE) && st_next == ST_NORMAL &&
             history_reg && wantRef == curRef_reg;
    settle_next = 16'h0;
    if (st_next == ST_NORMAL && st_reg == ST_NORMAL && curRef_next == curRef_reg) begin
      settle_next = (settle_reg == `DSM_LOCK_SETTLE) ? settle_reg : settle_reg + 16'h1;
    end
    lock_next = (st_next == ST_NORMAL) && (settle_next == `DSM_LOCK_SETTLE);
    history_next = history_reg | lock_reg;
    hold_next = (st_next == ST_HOLD);
    oen_next = (st_next == ST_RST);
    refPrev_next = sync_reg.refs;
    selEdge = sync_reg.refs[curRef_reg] & ~refPrev_reg[curRef_reg];
    phase_next = selEdge ? 16'h0 : (phase_reg == `DSM_CNT_MAX ? phase_reg : phase_reg + 16'h1);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_reg <= ST_RST;
      rstCnt_reg <= 16'h0;
      curRef_reg <= 2'h0;
      settle_reg <= 16'h0;
      lock_reg <= 1'b0;
      history_reg <= 1'b0;
      hold_reg <= 1'b0;
      oen_reg <= 1'b1;
      refPrev_reg <= 3'h0;
      phase_reg <= 16'h0;
    end else begin
      st_reg <= st_next;
      rstCnt_reg <= rstCnt_next;
      curRef_reg <= curRef_next;
      settle_reg <= settle_next;
      lock_reg <= lock_next;
      history_reg <= history_next;
      hold_reg <= hold_next;
      oen_reg <= oen_next;
      refPrev_reg <= refPrev_next;
      phase_reg <= phase_next;
    end
  end

  assign tieBus.retEvt = retEvt;
  assign tieBus.hitless = sync_reg.hit;
  assign tieBus.phase = phase_reg;

  dsm_phase_corrector u_corr (
    .clock(clock),
    .srst(srst),
    .bus(tieBus.corr)
  );

  // register port and interrupts; a read of the interrupt status clears it, new events win
  always_comb begin
    ctrlRef_next = ctrlRef_reg;
    mask_next = mask_reg;
    rd_next = 32'h0;
    intStat_next = intStat_reg;
    faultPrev_next = refFault;
    events = {refFault & ~faultPrev_reg, hold_next & ~hold_reg, lock_reg & ~lock_next};
    if (regWrStb) begin
      if (regAddr == `DSM_REG_CTRL) ctrlRef_next = regWrData[`DSM_CTRL_REF];
      else if (regAddr == `DSM_REG_INT_MASK) mask_next = regWrData[`DSM_EV_FIELD];
    end
    if (regRdStb) begin
      if (regAddr == `DSM_REG_CTRL) rd_next = 32'(ctrlRef_reg);
      else if (regAddr == `DSM_REG_STATUS) rd_next = 32'({refFault, hold_reg, lock_reg});
      else if (regAddr == `DSM_REG_INT_STAT) begin
        rd_next = 32'(intStat_reg);
        intStat_next = 5'h0;
      end
      else if (regAddr == `DSM_REG_INT_MASK) rd_next = 32'(mask_reg);
      else if (regAddr == `DSM_REG_DELAY) rd_next = 32'(tieBus.delay);
    end
    intStat_next = intStat_next | events;
    irq_next = |(intStat_next & mask_next);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ctrlRef_reg <= 2'h0;
      mask_reg <= 5'h0;
      rd_reg <= 32'h0;
      intStat_reg <= 5'h0;
      faultPrev_reg <= 3'h0;
      irq_reg <= 1'b0;
    end else begin
      ctrlRef_reg <= ctrlRef_next;
      mask_reg <= mask_next;
      rd_reg <= rd_next;
      intStat_reg <= intStat_next;
      faultPrev_reg <= faultPrev_next;
      irq_reg <= irq_next;
    end
  end

  assign lockIndicator = lock_reg;
  assign holdoverIndicator = hold_reg;
  assign ref_a_fault_flag = refFault[0];
  assign ref_b_fault_flag = refFault[1];
  assign ref_c_fault_flag = refFault[2];
  assign clkOutEn_n = oen_reg;
  assign regRdData = rd_reg;
  assign irq = irq_reg;
  assign corrDelay = tieBus.delay;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  lock_in_normal_a: assert property (lockIndicator |-> st_reg == ST_NORMAL)
    else $error("lock high outside normal mode");
  lock_settled_a: assert property ($rose(lockIndicator) |->
      $past(st_reg == ST_NORMAL) && $past(st_reg == ST_NORMAL, 8))
    else $error("lock rose without a settled normal period");
  hold_flag_a: assert property ((st_reg == ST_HOLD) == holdoverIndicator)
    else $error("holdover output disagrees with state");
  free_mode_a: assert property (!inReset && sync_reg.mode == MODE_FREE |=>
      st_reg == ST_FREE && !lockIndicator)
    else $error("freerun code not obeyed");
  hold_mode_a: assert property (!inReset && sync_reg.mode == MODE_HOLD && history_reg |=>
      holdoverIndicator)
    else $error("holdover code not obeyed");
  reset_hiz_a: assert property ($fell(srst) |-> clkOutEn_n [*8])
    else $error("clock outputs driven early in internal reset");
  reset_len_a: assert property (inReset && rstCnt_reg != RST_LAST |=> inReset && clkOutEn_n)
    else $error("internal reset ended early");
  profile_limit_a: assert property ($changed(sync_reg.app) && sync_reg.app == 2'h0 |->
      oorLimit == OOR_LIMIT0)
    else $error("profile did not choose its limit");

  lock_seen_c: cover property ($rose(lockIndicator));
  hold_seen_c: cover property ($rose(holdoverIndicator));
  hitless_ret_c: cover property (retEvt && sync_reg.hit);
  fault_seen_c: cover property ($rose(ref_a_fault_flag));
endmodule

/* tb/dsm_board_model.sv */
// board controller model: makes the three reference clocks and drives the mode straps
// assumes the bench sets the requests; periods are in master clock cycles, 0 stops a ref
`timescale 1ns/100ps
module dsm_board_model (
  // clock
  input wire logic clock,
  // requests from the bench
  input wire logic [23:0] periods,
  input wire logic [5:0] stretch,
  input wire logic [1:0] modeReq,
  input wire logic [1:0] profileReq,
  input wire logic hitReq,
  // board pins
  output logic [2:0] refClkPin,
  output logic op_mode_bit0,
  output logic op_mode_bit1,
  output logic [1:0] application_profile,
  output logic hitless_return_select
);
  int cnt[3] = '{0, 0, 0};
  int nPer[3] = '{0, 0, 0};
  // a stretched period is one cycle longer, every s-th period; keeps jumps within one cycle
  function automatic int plen(int i);
    int s;
    s = stretch[i*2+:2];
    return periods[i*8+:8] + ((s != 0 && (nPer[i] % s) == s - 1) ? 1 : 0);
  endfunction
  initial begin
    refClkPin = 3'h0;
    {op_mode_bit1, op_mode_bit0} = 2'h0;
    application_profile = 2'h0;
    hitless_return_select = 1'h0;
  end
  always @(posedge clock) begin
    {op_mode_bit1, op_mode_bit0} <= modeReq;
    application_profile <= profileReq;
    hitless_return_select <= hitReq;
    for (int i = 0; i < 3; i++) begin
      if (periods[i*8+:8] == 8'h00) begin
        // a dead reference sits low rather than keeping its last level
        refClkPin[i] <= 1'h0;
        cnt[i] <= 0;
      end else begin
        if (cnt[i] + 1 >= plen(i)) begin
          cnt[i] <= 0;
          nPer[i] <= nPer[i] + 1;
        end else begin
          cnt[i] <= cnt[i] + 1;
        end
        refClkPin[i] <= (cnt[i] < periods[i*8+:8] / 2);
      end
    end
  end
endmodule

/* tb/dsm_status_mode_tb_top.sv */
// self-checking bench for the pll status and mode-pin block
// assumes the board model for pins; register port driven directly by the bench
`timescale 1ns/100ps
`include "dsm_regs.svh"
module dsm_status_mode_tb_top;
  import dsm_pkg::*;
  localparam int HOLD_CYC = 20;
  logic clock = 1'h0;
  logic srst = 1'h1;
  logic [23:0] periods = 24'h080808;
  logic [5:0] stretch = 6'h00;
  logic [1:0] modeReq = `DSM_MODE_NORMAL;
  logic [1:0] profileReq = 2'h0;
  logic hitReq = 1'h0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWrStb = 1'h0;
  logic regRdStb = 1'h0;
  logic [2:0] refClkPin;
  logic op_mode_bit0, op_mode_bit1, hitless_return_select;
  logic [1:0] application_profile;
  logic lockIndicator, holdoverIndicator, clkOutEn_n, irq;
  logic ref_a_fault_flag, ref_b_fault_flag, ref_c_fault_flag;
  logic [31:0] regRdData, r;
  logic [15:0] corrDelay, d;
  logic [1:0] mt[4];
  logic expL[4], expH[4];
  int n_fail = 0;
  int checked = 0;
  int k, seen[$];

  always #50 clock = ~clock;

  dsm_board_model i_board (.clock(clock), .periods(periods), .stretch(stretch),
    .modeReq(modeReq), .profileReq(profileReq), .hitReq(hitReq), .refClkPin(refClkPin),
    .op_mode_bit0(op_mode_bit0), .op_mode_bit1(op_mode_bit1),
    .application_profile(application_profile), .hitless_return_select(hitless_return_select));

  dsm_status_mode #(.RESET_HOLD_CYC(HOLD_CYC)) i_dut (.clock(clock), .srst(srst),
    .refClkPin(refClkPin), .op_mode_bit0(op_mode_bit0), .op_mode_bit1(op_mode_bit1),
    .application_profile(application_profile), .hitless_return_select(hitless_return_select),
    .lockIndicator(lockIndicator), .holdoverIndicator(holdoverIndicator),
    .ref_a_fault_flag(ref_a_fault_flag), .ref_b_fault_flag(ref_b_fault_flag),
    .ref_c_fault_flag(ref_c_fault_flag), .clkOutEn_n(clkOutEn_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .irq(irq), .corrDelay(corrDelay));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t ns: saw %h expected %h", $time, got, exp);
    end
  endtask
  // waits end on the falling edge so outputs are settled when looked at
  task automatic waitc(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    regAddr <= a;
    regWrData <= v;
    regWrStb <= 1'h1;
    @(posedge clock);
    regWrStb <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    regAddr <= a;
    regRdStb <= 1'h1;
    @(posedge clock);
    regRdStb <= 1'h0;
    @(negedge clock);
    v = regRdData;
  endtask
  task automatic pins(input logic [1:0] m, input logic h);
    @(posedge clock);
    modeReq <= m;
    hitReq <= h;
  endtask
  // fault expected from the mean edge count per 1024-cycle window of an 8-cycle ref
  function automatic logic exp_fault(input int p, input int s);
    int lim[4];
    lim[0] = `DSM_OOR_LIMIT0;
    lim[1] = `DSM_OOR_LIMIT1;
    lim[2] = `DSM_OOR_LIMIT2;
    lim[3] = `DSM_OOR_LIMIT3;
    return (128 - (1024 * s) / (8 * s + 1)) > lim[p];
  endfunction
  task automatic wrap_up();
    $display("checked %0d, failed %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    n_fail++;
    $display("ERROR %0t ns: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    mt = '{`DSM_MODE_HOLD, `DSM_MODE_FREE, `DSM_MODE_AUTO, `DSM_MODE_NORMAL};
    expL = '{1'h0, 1'h0, 1'h1, 1'h1};
    expH = '{1'h1, 1'h0, 1'h0, 1'h0};
    void'($urandom(94));
    repeat (5) @(posedge clock);
    srst <= 1'h0;
    @(negedge clock);
    check({lockIndicator, holdoverIndicator, ref_a_fault_flag, ref_b_fault_flag,
      ref_c_fault_flag}, 32'h0);
    k = 0;
    while (clkOutEn_n !== 1'h0 && k < 100) begin
      @(negedge clock);
      k++;
    end
    check(k >= HOLD_CYC && k <= HOLD_CYC + 4, 32'h1);
    $display("test reset done");
    waitc(2600);
    check({lockIndicator, holdoverIndicator}, 32'h2);
    rd(`DSM_REG_STATUS, r);
    check(r, 32'h1);
    wr(8'h20, $urandom());
    rd(8'h20, r);
    check(r, 32'h0);
    wr(`DSM_REG_STATUS, 32'h1f);
    rd(`DSM_REG_STATUS, r);
    check(r, 32'h1);
    $display("test lock done");
    for (int i = 0; i < 4; i++) begin
      pins(mt[i], 1'h0);
      waitc(1500);
      check(lockIndicator, expL[i]);
      check(holdoverIndicator, expH[i]);
    end
    $display("test modes done");
    for (int i = 0; i < 4; i++) begin
      pins(`DSM_MODE_HOLD, 1'h1);
      waitc(20 + $urandom_range(7, 0));
      pins(`DSM_MODE_NORMAL, 1'h1);
      waitc(20);
      check(corrDelay < 16'h0008, 32'h1);
      seen.push_back(corrDelay);
    end
    k = 0;
    foreach (seen[i]) k += (seen[i] != seen[0]);
    check(k > 0, 32'h1);
    d = corrDelay;
    pins(`DSM_MODE_HOLD, 1'h0);
    waitc(20 + $urandom_range(7, 0));
    pins(`DSM_MODE_NORMAL, 1'h0);
    waitc(20);
    check(corrDelay, d);
    rd(`DSM_REG_DELAY, r);
    check(r, {16'h0, d});
    $display("test hitless done");
    for (int p = 0; p < 4; p++) begin
      for (int s = 2; s < 4; s++) begin
        @(posedge clock);
        profileReq <= p[1:0];
        stretch[3:2] <= s[1:0];
        waitc(2200);
        check(ref_b_fault_flag, exp_fault(p, s));
      end
    end
    stretch <= 6'h00;
    waitc(2200);
    check(ref_b_fault_flag, 32'h0);
    periods[23:16] <= 8'h0b;
    waitc(40);
    check(ref_c_fault_flag, 32'h1);
    periods[23:16] <= 8'h08;
    waitc(2200);
    check(ref_c_fault_flag, 32'h0);
    $display("test monitor done");
    wr(`DSM_REG_INT_MASK, 32'h0);
    rd(`DSM_REG_INT_STAT, r);
    periods[7:0] <= 8'h0c;
    waitc(1300);
    check({lockIndicator, holdoverIndicator, ref_a_fault_flag}, 32'h3);
    check(irq, 32'h0);
    wr(`DSM_REG_INT_MASK, 32'h1f);
    waitc(2);
    check(irq, 32'h1);
    rd(`DSM_REG_INT_STAT, r);
    check(r, 32'h7);
    waitc(2);
    check(irq, 32'h0);
    rd(`DSM_REG_STATUS, r);
    check(r, 32'h6);
    $display("test failure done");
    wrap_up();
  end
endmodule
